// [design/mlpc_pkg.sv]
// Contract
// - close packet at max size, or at min size once gap timer expires
// - pmp master sends each packet one plus retransmit count times
// - select 65535: sync to any upstream unit with our network address
// - select 1..65534: sync only with upstream unit of that address
// - upstream unit select resets to 1, the master address
// - mesh: read-only signal level averaged over last 8 hop intervals
// - pp/pmp remotes report average level from their upstream unit
// - pp/pmp master reports average level from downstream units
// - averaged level drives three signal level status lines
// - master keeps level lines off until a downstream packet is seen
// - mesh: unacked count reaching limit drops route, starts discovery
// - nosync intake 1 keeps serial data while unsynced, 0 discards it
// - nosync intake setting has no effect on a master
// - gap timer counts quarter character times, default 10
// - gap timer runs only after min size; longer gap closes packet
`default_nettype none
package mlpc_pkg;
   // ----------------------------------------
   // register word addresses
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_UP_SEL = 4'h1;
   localparam logic [3:0] ADDR_MIN = 4'h2;
   localparam logic [3:0] ADDR_MAX = 4'h3;
   localparam logic [3:0] ADDR_RETX = 4'h4;
   localparam logic [3:0] ADDR_GAP = 4'h5;
   localparam logic [3:0] ADDR_LIM = 4'h6;
   localparam logic [3:0] ADDR_NOSYNC = 4'h7;
   localparam logic [3:0] ADDR_UP_AVG = 4'h8;
   localparam logic [3:0] ADDR_DN_AVG = 4'h9;
   localparam logic [3:0] ADDR_STAT = 4'ha;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int CTRL_MASTER_BIT = 2;
   localparam logic [15:0] RST_UP_SEL = 16'h0001;
   localparam logic [15:0] ROAM_ALL = 16'hffff;
   localparam logic [7:0] RST_MIN = 8'h01;
   localparam logic [8:0] RST_MAX = 9'h100;
   localparam logic [7:0] RST_RETX = 8'h03;
   localparam logic [7:0] RST_GAP = 8'h0a;
   localparam logic [7:0] RST_LIM = 8'h09;
   localparam logic RST_NOSYNC = 1'b0;
   // ----------------------------------------
   // signal level scale, dbm two's complement
   // ----------------------------------------
   localparam logic [7:0] DBM_FLOOR = 8'h92;
   localparam logic [7:0] LVL_TH1 = 8'h9c;
   localparam logic [7:0] LVL_TH2 = 8'hab;
   localparam logic [7:0] LVL_TH3 = 8'hba;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 8;

   typedef enum logic [1:0] {MODE_PMP, MODE_PP, MODE_MESH} mlpc_mode_type;

   typedef struct packed {
      logic vld;
      logic [15:0] unit_addr;
      logic net_match;
   } mlpc_beacon_type;

   typedef struct packed {
      logic vld;
      logic [7:0] dbm;
      logic from_dn;
   } mlpc_rssi_type;

   typedef struct packed {
      logic close;
      logic [8:0] len;
      logic [8:0] copies;
   } mlpc_pkt_type;
endpackage
`default_nettype wire

// [design/mlpc_link_ctrl.sv]
`default_nettype none
// ----------------------------------------
// byte fifo
// ----------------------------------------
module mlpc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic in_vld,
   output logic in_rdy,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_vld,
   input wire logic out_rdy,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } mlpc_ptr_type;
   mlpc_ptr_type ptr_ff, nxt_ptr;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty;

   assign empty = ptr_ff.wp == ptr_ff.rp;
   assign full = ptr_ff.wp == {~ptr_ff.rp[AW], ptr_ff.rp[AW-1:0]};
   assign in_rdy = !full;
   assign out_vld = !empty;
   assign out_data = mem[ptr_ff.rp[AW-1:0]];

   always_comb begin
      nxt_ptr = ptr_ff;
      if (in_vld && !full) begin
         nxt_ptr.wp = ptr_ff.wp + 1'b1;
      end
      if (out_rdy && !empty) begin
         nxt_ptr.rp = ptr_ff.rp + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ptr_ff <= '0;
      end else begin
         ptr_ff <= nxt_ptr;
      end
      if (in_vld && !full) begin
         mem[ptr_ff.wp[AW-1:0]] <= in_data;
      end
   end
endmodule

// ----------------------------------------
// link packet control
// ----------------------------------------
module mlpc_link_ctrl
   import mlpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic synced,
   input wire logic ser_vld,
   output logic ser_rdy,
   input wire logic [7:0] ser_data,
   input wire logic quarter_tick,
   output logic pkt_vld,
   input wire logic pkt_rdy,
   output logic [7:0] pkt_data,
   output mlpc_pkt_type pkt,
   input wire mlpc_beacon_type beacon,
   output logic sync_accept,
   output logic [15:0] upstream_lock,
   input wire logic hop_tick,
   input wire mlpc_rssi_type rssi,
   output logic [2:0] signal_level_lines,
   input wire logic tx_done,
   input wire logic tx_acked,
   output logic route_drop
);
   typedef struct packed {
      mlpc_mode_type mode;
      logic master;
      logic [15:0] up_sel;
      logic [7:0] min_sz;
      logic [8:0] max_sz;
      logic [7:0] retx;
      logic [7:0] gap_to;
      logic [7:0] lim;
      logic nosync;
      logic [8:0] cnt;
      logic [8:0] gap;
      mlpc_pkt_type pkt;
      logic [7:0][7:0] up_hist;
      logic [7:0][7:0] dn_hist;
      logic [7:0] up_cur;
      logic [7:0] dn_cur;
      logic [7:0] up_avg;
      logic [7:0] dn_avg;
      logic dn_valid;
      logic [2:0] lvl;
      logic [7:0] fails;
      logic drop;
      logic acc;
      logic [15:0] lock;
      logic [15:0] rdata;
   } mlpc_state_type;

   mlpc_state_type st_ff, nxt_st;
   logic keep, fifo_rdy, byte_in, timer_close;

   // mean of eight signed readings; shift keeps sign
   function automatic logic [7:0] avg8(input logic [7:0][7:0] h);
      logic signed [10:0] s;
      s = '0;
      for (int i = 0; i < 8; i++) begin
         s = s + 11'(signed'(h[i]));
      end
      return s[10:3];
   endfunction

   // thermometer code on three lines, stronger level lights more
   function automatic logic [2:0] therm(input logic [7:0] d);
      logic signed [7:0] v;
      v = signed'(d);
      return {v >= signed'(LVL_TH3), v >= signed'(LVL_TH2),
              v >= signed'(LVL_TH1)};
   endfunction

   // ----------------------------------------
   // serial intake and fifo
   // ----------------------------------------
   // discarded bytes are still consumed so the port never stalls on them
   assign keep = synced || st_ff.nosync || st_ff.master;
   assign byte_in = ser_vld && keep && fifo_rdy;
   assign ser_rdy = keep ? fifo_rdy : 1'b1;
   assign timer_close = !byte_in && st_ff.cnt != '0 &&
      st_ff.cnt >= {1'b0, st_ff.min_sz} &&
      st_ff.gap > {1'b0, st_ff.gap_to};

   mlpc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_vld(ser_vld && keep),
      .in_rdy(fifo_rdy),
      .in_data(ser_data),
      .out_vld(pkt_vld),
      .out_rdy(pkt_rdy),
      .out_data(pkt_data)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pkt.close = 1'b0;
      nxt_st.drop = 1'b0;
      nxt_st.acc = 1'b0;
      nxt_st.rdata = '0;
      // ----------------------------------------
      // register writes and reads
      // ----------------------------------------
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL: begin
               nxt_st.mode = mlpc_mode_type'(reg_wdata[1:0]);
               nxt_st.master = reg_wdata[CTRL_MASTER_BIT];
            end
            ADDR_UP_SEL: nxt_st.up_sel = reg_wdata;
            ADDR_MIN: nxt_st.min_sz = reg_wdata[7:0];
            ADDR_MAX: nxt_st.max_sz = reg_wdata[8:0];
            ADDR_RETX: nxt_st.retx = reg_wdata[7:0];
            ADDR_GAP: nxt_st.gap_to = reg_wdata[7:0];
            ADDR_LIM: nxt_st.lim = reg_wdata[7:0];
            ADDR_NOSYNC: nxt_st.nosync = reg_wdata[0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: nxt_st.rdata = {13'h0000, st_ff.master,
                                       st_ff.mode};
            ADDR_UP_SEL: nxt_st.rdata = st_ff.up_sel;
            ADDR_MIN: nxt_st.rdata = {8'h00, st_ff.min_sz};
            ADDR_MAX: nxt_st.rdata = {7'h00, st_ff.max_sz};
            ADDR_RETX: nxt_st.rdata = {8'h00, st_ff.retx};
            ADDR_GAP: nxt_st.rdata = {8'h00, st_ff.gap_to};
            ADDR_LIM: nxt_st.rdata = {8'h00, st_ff.lim};
            ADDR_NOSYNC: nxt_st.rdata = {15'h0000, st_ff.nosync};
            ADDR_UP_AVG: nxt_st.rdata = {8'h00, st_ff.up_avg};
            ADDR_DN_AVG: nxt_st.rdata = {8'h00, st_ff.dn_avg};
            ADDR_STAT: nxt_st.rdata = {8'h00, st_ff.fails};
            default: nxt_st.rdata = '0;
         endcase
      end
      // ----------------------------------------
      // packet closing
      // ----------------------------------------
      if (byte_in) begin
         nxt_st.gap = '0;
         if (st_ff.cnt + 9'h001 >= st_ff.max_sz) begin
            nxt_st.cnt = '0;
            nxt_st.pkt.close = 1'b1;
            nxt_st.pkt.len = st_ff.cnt + 9'h001;
         end else begin
            nxt_st.cnt = st_ff.cnt + 9'h001;
         end
      end else if (timer_close) begin
         nxt_st.cnt = '0;
         nxt_st.gap = '0;
         nxt_st.pkt.close = 1'b1;
         nxt_st.pkt.len = st_ff.cnt;
      end else if (quarter_tick && st_ff.cnt != '0 &&
                   st_ff.cnt >= {1'b0, st_ff.min_sz}) begin
         // saturate so a long silence cannot wrap back below timeout
         if (st_ff.gap != 9'h1ff) begin
            nxt_st.gap = st_ff.gap + 9'h001;
         end
      end
      if (st_ff.master && st_ff.mode == MODE_PMP) begin
         nxt_st.pkt.copies = {1'b0, st_ff.retx} + 9'h001;
      end else begin
         nxt_st.pkt.copies = 9'h001;
      end
      // ----------------------------------------
      // upstream selection
      // ----------------------------------------
      if (beacon.vld && beacon.net_match && !st_ff.master &&
          (st_ff.up_sel == ROAM_ALL ||
           beacon.unit_addr == st_ff.up_sel)) begin
         nxt_st.acc = 1'b1;
         nxt_st.lock = beacon.unit_addr;
      end
      // ----------------------------------------
      // signal level averaging
      // ----------------------------------------
      if (rssi.vld && rssi.from_dn) begin
         nxt_st.dn_cur = rssi.dbm;
         nxt_st.dn_valid = 1'b1;
      end else if (rssi.vld) begin
         nxt_st.up_cur = rssi.dbm;
      end
      if (hop_tick) begin
         nxt_st.up_hist = {st_ff.up_hist[6:0], st_ff.up_cur};
         nxt_st.dn_hist = {st_ff.dn_hist[6:0], st_ff.dn_cur};
         nxt_st.up_avg = avg8(nxt_st.up_hist);
         nxt_st.dn_avg = avg8(nxt_st.dn_hist);
         // silent interval counts as floor level
         nxt_st.up_cur = DBM_FLOOR;
         nxt_st.dn_cur = DBM_FLOOR;
      end
      if (st_ff.master) begin
         nxt_st.lvl = st_ff.dn_valid ? therm(st_ff.dn_avg) :
                      3'b000;
      end else begin
         nxt_st.lvl = therm(st_ff.up_avg);
      end
      // ----------------------------------------
      // mesh route attempts
      // ----------------------------------------
      if (tx_done && st_ff.mode == MODE_MESH) begin
         if (tx_acked) begin
            nxt_st.fails = '0;
         end else if (st_ff.fails + 8'h01 >= st_ff.lim) begin
            nxt_st.fails = '0;
            nxt_st.drop = 1'b1;
         end else begin
            nxt_st.fails = st_ff.fails + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.mode <= MODE_PMP;
         st_ff.up_sel <= RST_UP_SEL;
         st_ff.min_sz <= RST_MIN;
         st_ff.max_sz <= RST_MAX;
         st_ff.retx <= RST_RETX;
         st_ff.gap_to <= RST_GAP;
         st_ff.lim <= RST_LIM;
         st_ff.nosync <= RST_NOSYNC;
         st_ff.up_hist <= {8{DBM_FLOOR}};
         st_ff.dn_hist <= {8{DBM_FLOOR}};
         st_ff.up_cur <= DBM_FLOOR;
         st_ff.dn_cur <= DBM_FLOOR;
         st_ff.up_avg <= DBM_FLOOR;
         st_ff.dn_avg <= DBM_FLOOR;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign pkt = st_ff.pkt;
   assign sync_accept = st_ff.acc;
   assign upstream_lock = st_ff.lock;
   assign signal_level_lines = st_ff.lvl;
   assign route_drop = st_ff.drop;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   max_close_a: assert property (
      byte_in && st_ff.cnt + 9'h001 == st_ff.max_sz |=>
      pkt.close && pkt.len == st_ff.max_sz && st_ff.cnt == '0)
      else $error("packet not closed at max size");
   gap_close_a: assert property (
      timer_close |=> pkt.close && pkt.len == $past(st_ff.cnt))
      else $error("gap expiry did not close packet");
   gap_idle_a: assert property (
      !byte_in && st_ff.cnt < {1'b0, st_ff.min_sz} |=> !pkt.close)
      else $error("packet closed below min size");
   copies_a: assert property (
      pkt.close && st_ff.master && st_ff.mode == MODE_PMP && !$past(reg_wr)
      |-> pkt.copies == {1'b0, st_ff.retx} + 9'h001)
      else $error("wrong transmission count");
   roam_a: assert property (
      beacon.vld && beacon.net_match && !st_ff.master &&
      st_ff.up_sel == ROAM_ALL |=> sync_accept)
      else $error("roaming beacon not accepted");
   fixed_a: assert property (
      sync_accept |-> $past(st_ff.up_sel) == ROAM_ALL ||
      upstream_lock == $past(st_ff.up_sel))
      else $error("synced to wrong upstream unit");
   sel_reset_a: assert property (
      disable iff (1'b0) !rst_b |=> st_ff.up_sel == RST_UP_SEL)
      else $error("upstream select reset wrong");
   lvl_off_a: assert property (
      st_ff.master && !st_ff.dn_valid ##1 st_ff.master |->
      signal_level_lines == 3'b000)
      else $error("master level lines lit early");
   hist_a: assert property (
      hop_tick |=> st_ff.up_hist[0] == $past(st_ff.up_cur) &&
      st_ff.up_hist[7] == $past(st_ff.up_hist[6]))
      else $error("hop history not shifted");
   drop_a: assert property (
      tx_done && !tx_acked && st_ff.mode == MODE_MESH &&
      st_ff.fails + 8'h01 >= st_ff.lim |=> route_drop && st_ff.fails == '0)
      else $error("route not dropped at limit");
   ack_a: assert property (
      tx_done && tx_acked && st_ff.mode == MODE_MESH |=>
      st_ff.fails == '0 && !route_drop)
      else $error("ack did not clear attempts");
   gate_a: assert property (
      ser_vld && !synced && !st_ff.nosync && !st_ff.master |->
      ser_rdy && !byte_in)
      else $error("unsynced byte kept");
   master_keep_a: assert property (
      st_ff.master && ser_vld && fifo_rdy |-> byte_in)
      else $error("master dropped serial byte");
   up_lines_a: assert property (
      !st_ff.master && signed'(st_ff.up_avg) >= signed'(LVL_TH3) |=>
      signal_level_lines == 3'b111)
      else $error("level lines not lit for strong signal");

   max_pkt_c: cover property (byte_in ##1 pkt.close && pkt.len == RST_MAX);
   gap_pkt_c: cover property (timer_close ##1 pkt.close);
   drop_c: cover property (route_drop);
   full_c: cover property (ser_vld && keep && !fifo_rdy);
   lvl_lit_c: cover property (st_ff.master && signal_level_lines != 3'b000);
endmodule
`default_nettype wire

// [verification/mlpc_peer_model.sv]
`default_nettype none
// ----------------------------------------
// packet sink on the far side of the fifo
// ----------------------------------------
module mlpc_peer_model
   import mlpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic stall,
   input wire logic pkt_vld,
   input wire logic [7:0] pkt_data,
   output logic pkt_rdy,
   output logic [15:0] rx_count,
   output logic [15:0] rx_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow_ff;
   // ready drops every other cycle in some stretches, so the
   // fifo sees a slow consumer as well as a prompt one
   assign pkt_rdy = !stall && !slow_ff;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slow_ff <= 1'b0;
         rx_count <= 16'h0000;
         rx_bad <= 16'h0000;
      end else begin
         slow_ff <= !slow_ff && rx_count[3];
         if (pkt_vld && pkt_rdy) begin
            rx_count <= rx_count + 16'h0001;
            // bytes must leave in the order they came in
            if (pkt_data !== rx_count[7:0]) begin
               rx_bad <= rx_bad + 16'h0001;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verification/modem_link_packet_control_tb.sv]
`default_nettype none
module modem_link_packet_control_tb
   import mlpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, reg_wr, reg_rd, synced, ser_vld, ser_rdy;
   logic quarter_tick, pkt_vld, pkt_rdy, sync_accept, hop_tick;
   logic tx_done, tx_acked, route_drop, stall;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, upstream_lock, rx_count, rx_bad, v;
   logic [7:0] ser_data, pkt_data;
   logic [2:0] signal_level_lines;
   logic [8:0] last_len, last_cp;
   mlpc_pkt_type pkt;
   mlpc_beacon_type beacon;
   mlpc_rssi_type rssi;
   int err_total, compares, kc, close_n, acc_n, drop_n, c0, n, first;
   bit ok;
   logic [15:0] tab [3][3] = '{'{16'h0004, 16'h0005, 16'h0006},
      '{16'h0005, 16'h0005, 16'h0001}, '{16'h0006, 16'h0001, 16'h0001}};

   mlpc_link_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .synced(synced), .ser_vld(ser_vld),
      .ser_rdy(ser_rdy), .ser_data(ser_data), .quarter_tick(quarter_tick),
      .pkt_vld(pkt_vld), .pkt_rdy(pkt_rdy), .pkt_data(pkt_data), .pkt(pkt),
      .beacon(beacon), .sync_accept(sync_accept),
      .upstream_lock(upstream_lock), .hop_tick(hop_tick), .rssi(rssi),
      .signal_level_lines(signal_level_lines), .tx_done(tx_done),
      .tx_acked(tx_acked), .route_drop(route_drop));
   mlpc_peer_model u_peer (.mclk(mclk), .rst_b(rst_b), .stall(stall),
      .pkt_vld(pkt_vld), .pkt_data(pkt_data), .pkt_rdy(pkt_rdy),
      .rx_count(rx_count), .rx_bad(rx_bad));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ----------------------------------------
   // pulse monitors
   // ----------------------------------------
   always @(posedge mclk) begin
      if (pkt.close === 1'b1) begin
         close_n <= close_n + 1;
         last_len <= pkt.len;
         last_cp <= pkt.copies;
      end
      if (sync_accept === 1'b1) acc_n <= acc_n + 1;
      if (route_drop === 1'b1) drop_n <= drop_n + 1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic print_verdict();
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic send(input int cnt, input bit keep);
      bit got;
      for (int i = 0; i < cnt; i++) begin
         ser_data <= keep ? kc[7:0] : 8'hee;
         ser_vld <= 1'b1;
         got = 0;
         for (int k = 0; k < 50 && !got; k++) begin
            @(negedge mclk);
            got = (ser_rdy === 1'b1);
            @(posedge mclk);
         end
         if (!got) begin
            err_total++;
            print_verdict();
         end
         if (keep) kc++;
      end
      ser_vld <= 1'b0;
   endtask
   // a tick is followed by settle time so a close lands in close_n
   task automatic tick(input int cnt);
      repeat (cnt) begin
         quarter_tick <= 1'b1;
         @(posedge mclk);
         quarter_tick <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask
   task automatic bcn(input logic [15:0] u, input logic m);
      beacon <= '{vld: 1'b1, unit_addr: u, net_match: m};
      @(posedge mclk);
      beacon <= '0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic lvl(input logic [7:0] d, input logic fd);
      repeat (8) begin
         rssi <= '{vld: 1'b1, dbm: d, from_dn: fd};
         @(posedge mclk);
         rssi <= '0;
         hop_tick <= 1'b1;
         @(posedge mclk);
         hop_tick <= 1'b0;
      end
      repeat (3) @(posedge mclk);
   endtask
   task automatic tx(input logic a);
      tx_done <= 1'b1;
      tx_acked <= a;
      @(posedge mclk);
      tx_done <= 1'b0;
      tx_acked <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_b, reg_wr, reg_rd, synced, ser_vld, quarter_tick} = '0;
      {hop_tick, tx_done, tx_acked, stall, reg_addr} = '0;
      {reg_wdata, ser_data, beacon, rssi} = '0;
      {err_total, compares, kc, close_n, acc_n, drop_n} = '0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(ADDR_UP_SEL, v);
      chk(v, 16'h0001);
      rd(ADDR_GAP, v);
      chk(v, 16'h000a);
      rd(ADDR_LIM, v);
      chk(v, 16'h0009);
      rd(ADDR_NOSYNC, v);
      chk(v, 16'h0000);
      rd(4'hb, v);
      chk(v, 16'h0000);
      // unsynced master fills the fifo while the sink stalls
      wr(ADDR_CTRL, 16'h0004);
      stall <= 1'b1;
      ser_vld <= 1'b1;
      ser_data <= kc[7:0];
      n = 0;
      repeat (40) begin
         @(negedge mclk);
         ok = (ser_rdy === 1'b1);
         @(posedge mclk);
         if (ok) begin
            kc++;
            n++;
            ser_data <= kc[7:0];
         end
      end
      ser_vld <= 1'b0;
      chk(16'(n), 16'(FIFO_DEPTH));
      stall <= 1'b0;
      for (int k = 0; k < 200 && rx_count != 16'(kc); k++) @(posedge mclk);
      chk(rx_count, 16'(kc));
      tick(12);
      chk(16'(close_n), 16'h0001);
      chk({7'h00, last_len}, 16'h0010);
      // gap close only once min size is gathered
      wr(ADDR_MIN, 16'h0003);
      c0 = close_n;
      send(2, 1);
      tick(14);
      chk(16'(close_n - c0), 16'h0000);
      send(1, 1);
      first = 0;
      for (int i = 1; i <= 14; i++) begin
         tick(1);
         if (close_n != c0 && first == 0) first = i;
      end
      chk(16'(first), 16'h000b);
      chk({7'h00, last_len}, 16'h0003);
      // close at max size; copies per mode and retransmit count
      wr(ADDR_MIN, 16'h0001);
      wr(ADDR_MAX, 16'h0002);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_CTRL, tab[0][i]);
         wr(ADDR_RETX, tab[1][i]);
         c0 = close_n;
         send(2, 1);
         repeat (3) @(posedge mclk);
         chk(16'(close_n - c0), 16'h0001);
         chk({7'h00, last_len}, 16'h0002);
         chk({7'h00, last_cp}, tab[2][i]);
      end
      // unsynced slave drops bytes unless intake is enabled
      wr(ADDR_CTRL, 16'h0000);
      c0 = close_n;
      send(2, 0);
      repeat (4) @(posedge mclk);
      chk(16'(close_n - c0), 16'h0000);
      wr(ADDR_NOSYNC, 16'h0001);
      send(2, 1);
      repeat (3) @(posedge mclk);
      chk(16'(close_n - c0), 16'h0001);
      wr(ADDR_NOSYNC, 16'h0000);
      // upstream selection
      c0 = acc_n;
      bcn(16'h0002, 1'b1);
      chk(16'(acc_n - c0), 16'h0000);
      bcn(16'h0001, 1'b1);
      chk(16'(acc_n - c0), 16'h0001);
      wr(ADDR_UP_SEL, 16'h0002);
      bcn(16'h0002, 1'b1);
      chk(upstream_lock, 16'h0002);
      wr(ADDR_UP_SEL, 16'hffff);
      bcn(16'h0007, 1'b0);
      chk(16'(acc_n - c0), 16'h0002);
      bcn(16'h0007, 1'b1);
      chk(upstream_lock, 16'h0007);
      // averaged signal level and status lines
      wr(ADDR_CTRL, 16'h0001);
      lvl(8'hc4, 1'b0);
      rd(ADDR_UP_AVG, v);
      chk({8'h00, v[7:0]}, 16'h00c4);
      chk({13'h0, signal_level_lines}, 16'h0007);
      wr(ADDR_CTRL, 16'h0002);
      lvl(8'hb0, 1'b0);
      rd(ADDR_UP_AVG, v);
      chk({8'h00, v[7:0]}, 16'h00b0);
      chk({13'h0, signal_level_lines}, 16'h0003);
      wr(ADDR_CTRL, 16'h0004);
      lvl(8'hc4, 1'b0);
      chk({13'h0, signal_level_lines}, 16'h0000);
      lvl(8'ha0, 1'b1);
      rd(ADDR_DN_AVG, v);
      chk({8'h00, v[7:0]}, 16'h00a0);
      chk({13'h0, signal_level_lines}, 16'h0001);
      wr(ADDR_DN_AVG, 16'h1234);
      rd(ADDR_DN_AVG, v);
      chk({8'h00, v[7:0]}, 16'h00a0);
      wr(4'hc, 16'h5555);
      rd(4'hc, v);
      chk(v, 16'h0000);
      // mesh unacknowledged count and route drop
      wr(ADDR_CTRL, 16'h0002);
      wr(ADDR_LIM, 16'h0003);
      c0 = drop_n;
      tx(1'b0);
      tx(1'b0);
      rd(ADDR_STAT, v);
      chk({8'h00, v[7:0]}, 16'h0002);
      tx(1'b1);
      rd(ADDR_STAT, v);
      chk({8'h00, v[7:0]}, 16'h0000);
      tx(1'b0);
      tx(1'b0);
      chk(16'(drop_n - c0), 16'h0000);
      tx(1'b0);
      chk(16'(drop_n - c0), 16'h0001);
      wr(ADDR_CTRL, 16'h0001);
      repeat (3) tx(1'b0);
      chk(16'(drop_n - c0), 16'h0001);
      for (int k = 0; k < 200 && rx_count != 16'(kc); k++) @(posedge mclk);
      chk(rx_count, 16'(kc));
      chk(rx_bad, 16'h0000);
      print_verdict();
   end
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
